// ### inc/pdt_pkg.sv
package pdt_pkg;

  // timer activity, gray along off -> count -> hold; count -> done changes both bits
  typedef enum logic [1:0] {
    PDT_ST_OFF   = 2'h0,
    PDT_ST_COUNT = 2'h1,
    PDT_ST_HOLD  = 2'h3,
    PDT_ST_DONE  = 2'h2
  } pdt_state_t;

  // mask of the low bits that divide by two to the code plus one
  function automatic logic [15:0] pdt_div_mask(input logic [3:0] code);
    pdt_div_mask = 16'hFFFF >> (4'hF - code);
  endfunction

endpackage

// ### inc/pdt_regs.svh
`ifndef PDT_REGS_SVH
`define PDT_REGS_SVH

// register indices on the plain register port
`define PDT_ADDR_W        4
`define PDT_OFS_CONTROL   4'h0
`define PDT_OFS_PERIOD    4'h1
`define PDT_OFS_COUNT     4'h2
`define PDT_OFS_STATUS    4'h3
`define PDT_OFS_CLEAR     4'h4
`define PDT_OFS_ENABLE    4'h5
`define PDT_OFS_STATE     4'h6

// widths
`define PDT_DATA_W        16
`define PDT_CTL_W         7
`define PDT_DIV_W         4

// timer control fields
`define PDT_BIT_DISABLE   6
`define PDT_BIT_RELOAD    5
`define PDT_BIT_CNTEN     4
`define PDT_DIV_HI        3
`define PDT_DIV_LO        0

// interrupt bit position in status, clear and enable
`define PDT_BIT_TIMEIRQ   8

// reset values
`define PDT_RST_CONTROL   7'h00
`define PDT_RST_PERIOD    16'h0000
`define PDT_RST_COUNT     16'h0000
`define PDT_RST_DATA      16'h0000
`define PDT_COUNT_ONE     16'h0001

`endif

// ### inc/pdt_tick_if.sv
interface pdt_tick_if;
  logic       run;
  logic [3:0] code;
  logic       tick;
  modport divider (input run, input code, output tick);
  modport timer (output run, output code, input tick);
endinterface

// ### rtl/pdt_prescaler.sv
module pdt_prescaler
  import pdt_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // tick control and tick out
  pdt_tick_if.divider tk
);
`include "pdt_regs.svh"

  logic [15:0] divCnt;
  logic [15:0] divMask;

  assign divMask = pdt_div_mask(tk.code);
  // one cycle tick each time the low bits wrap, only while running
  assign tk.tick = tk.run && ((divCnt & divMask) == divMask);

  // divider counter frozen while the timer is disabled
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      divCnt <= `PDT_RST_COUNT;
    end else if (tk.run) begin
      divCnt <= divCnt + `PDT_COUNT_ONE;
    end
  end

  // helper: running cycles since last tick and code change flag
  logic [16:0] gapCnt;
  logic        codeChg;
  logic [3:0]  codeSeen;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gapCnt   <= 17'h00000;
      codeChg  <= 1'b0;
      codeSeen <= 4'h0;
    end else begin
      codeSeen <= tk.code;
      if (tk.tick) begin
        gapCnt  <= 17'h00000;
        codeChg <= 1'b0;
      end else begin
        if (tk.run) begin
          gapCnt <= gapCnt + 17'h00001;
        end
        if (tk.code != codeSeen) begin
          codeChg <= 1'b1;
        end
      end
    end
  end

  chk_tick_spacing: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (tk.tick && !codeChg && tk.code == codeSeen) |-> gapCnt == {1'b0, divMask})
    else $error("tick spacing differs from divider code");

endmodule // pdt_prescaler

// ### rtl/pdt_timer.sv
// What this block does
// - disable bit stops timer and prescaler, period and count kept
// - reload clear: counter halts at zero and stays there
// - reload set: counter reloads from period at zero, forever
// - count-enable clear: counter frozen, no decrement or reload
// - count-enable set: counter decrements at the prescaled tick rate
// - divider code n gives tick rate of clock over two to n plus one
// - writing one to status bit 8 clears the pending timer interrupt
// - timer interrupt passes only while its enable bit is one
module pdt_timer
  import pdt_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdData,
  // interrupt
  output logic             timerIrq
);
`include "pdt_regs.svh"

  logic [`PDT_CTL_W-1:0]  control_reg;
  logic [`PDT_DATA_W-1:0] period_reg;
  logic [`PDT_DATA_W-1:0] liveCount_reg;
  logic                   pending_reg;
  logic                   irqEnable_reg;
  pdt_state_t             state_reg;
  pdt_state_t             state_next;

  logic       ctlDisable;
  logic       ctlReload;
  logic       countEnable;
  logic [3:0] tickDivider;
  logic       ctlWr;
  logic       perWr;
  logic       clrWr;
  logic       enWr;
  logic       tickUse;
  logic       zeroEvent;
  logic       pendClear;

  pdt_tick_if tickBus ();

  // write decode
  assign ctlWr = regWr && (regAddr == `PDT_OFS_CONTROL);
  assign perWr = regWr && (regAddr == `PDT_OFS_PERIOD);
  assign clrWr = regWr && (regAddr == `PDT_OFS_CLEAR);
  assign enWr  = regWr && (regAddr == `PDT_OFS_ENABLE);

  // control fields
  assign ctlDisable  = control_reg[`PDT_BIT_DISABLE];
  assign ctlReload   = control_reg[`PDT_BIT_RELOAD];
  assign countEnable = control_reg[`PDT_BIT_CNTEN];
  assign tickDivider = control_reg[`PDT_DIV_HI:`PDT_DIV_LO];

  // prescaler runs only while the timer is enabled
  assign tickBus.run  = !ctlDisable;
  assign tickBus.code = tickDivider;

  pdt_prescaler u_prescaler (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .tk      (tickBus)
  );

  // a tick seen by the counter: count-enable set and timer not disabled
  assign tickUse   = tickBus.tick && countEnable && !ctlDisable;
  // counter leaves one for zero on this tick
  assign zeroEvent = tickUse && !perWr && (liveCount_reg == `PDT_COUNT_ONE);

  // clear by status write one or by the clear register
  assign pendClear = (regWr && (regAddr == `PDT_OFS_STATUS) &&
                      regWrData[`PDT_BIT_TIMEIRQ]) ||
                     (clrWr && regWrData[`PDT_BIT_TIMEIRQ]);

  // control register, reserved upper bits not stored
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      control_reg <= `PDT_RST_CONTROL;
    end else if (ctlWr) begin
      control_reg <= regWrData[`PDT_CTL_W-1:0];
    end
  end

  // period register, kept across disable
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      period_reg <= `PDT_RST_PERIOD;
    end else if (perWr) begin
      period_reg <= regWrData;
    end
  end

  // live count: load on period write, else decrement or reload
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      liveCount_reg <= `PDT_RST_COUNT;
    end else if (perWr) begin
      liveCount_reg <= regWrData;
    end else if (tickUse) begin
      if (liveCount_reg != `PDT_RST_COUNT) begin
        liveCount_reg <= liveCount_reg - `PDT_COUNT_ONE;
      end else if (ctlReload) begin
        liveCount_reg <= period_reg;
      end
      // reload clear: stays at zero until software writes period
    end
  end

  // pending flag, a set in the clearing cycle wins
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pending_reg <= 1'b0;
    end else begin
      pending_reg <= (pending_reg && !pendClear) || zeroEvent;
    end
  end

  // interrupt enable
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqEnable_reg <= 1'b0;
    end else if (enWr) begin
      irqEnable_reg <= regWrData[`PDT_BIT_TIMEIRQ];
    end
  end

  // interrupt output straight from a flop
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timerIrq <= 1'b0;
    end else begin
      timerIrq <= pending_reg && irqEnable_reg;
    end
  end

  // activity state for software
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PDT_ST_OFF: begin
        if (!ctlDisable) begin
          state_next = countEnable ? PDT_ST_COUNT : PDT_ST_HOLD;
        end
      end
      PDT_ST_COUNT: begin
        if (ctlDisable) begin
          state_next = PDT_ST_OFF;
        end else if (!countEnable) begin
          state_next = PDT_ST_HOLD;
        end else if (liveCount_reg == `PDT_RST_COUNT && !ctlReload && !perWr) begin
          state_next = PDT_ST_DONE;
        end
      end
      PDT_ST_HOLD: begin
        if (ctlDisable) begin
          state_next = PDT_ST_OFF;
        end else if (countEnable) begin
          state_next = PDT_ST_COUNT;
        end
      end
      PDT_ST_DONE: begin
        if (ctlDisable) begin
          state_next = PDT_ST_OFF;
        end else if (perWr || ctlReload) begin
          state_next = PDT_ST_COUNT;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= PDT_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // read data in the cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= `PDT_RST_DATA;
    end else if (regRd) begin
      regRdData <= `PDT_RST_DATA;
      case (regAddr)
        `PDT_OFS_CONTROL: regRdData[`PDT_CTL_W-1:0] <= control_reg;
        `PDT_OFS_PERIOD:  regRdData <= period_reg;
        `PDT_OFS_COUNT:   regRdData <= liveCount_reg;
        `PDT_OFS_STATUS:  regRdData[`PDT_BIT_TIMEIRQ] <= pending_reg;
        `PDT_OFS_ENABLE:  regRdData[`PDT_BIT_TIMEIRQ] <= irqEnable_reg;
        `PDT_OFS_STATE:   regRdData[1:0] <= state_reg;
        default:          regRdData <= `PDT_RST_DATA;
      endcase
    end else begin
      regRdData <= `PDT_RST_DATA;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // no tick while disabled, count unchanged one cycle later
  chk_disable_freeze: assert property (
    (ctlDisable && !perWr) |-> !tickBus.tick ##1 (liveCount_reg == $past(liveCount_reg)))
    else $error("count or prescaler moved while disabled");

  chk_oneshot_halt: assert property (
    (liveCount_reg == `PDT_RST_COUNT && !ctlReload && !perWr)
      |=> liveCount_reg == `PDT_RST_COUNT)
    else $error("one-shot counter left zero by itself");

  chk_reload_zero: assert property (
    (tickUse && ctlReload && liveCount_reg == `PDT_RST_COUNT && !perWr)
      |=> liveCount_reg == $past(period_reg))
    else $error("counter did not reload from period");

  chk_hold_count: assert property (
    (!countEnable && !perWr) |=> $stable(liveCount_reg))
    else $error("counter moved with count enable clear");

  chk_count_dec: assert property (
    (tickUse && !perWr && liveCount_reg != `PDT_RST_COUNT)
      |=> liveCount_reg == $past(liveCount_reg) - `PDT_COUNT_ONE)
    else $error("counter did not decrement on tick");

  chk_no_tick_move: assert property (
    (!tickBus.tick && !perWr) |=> $stable(liveCount_reg))
    else $error("counter moved without a tick");

  chk_clear_pending: assert property (
    (pendClear && !zeroEvent) |=> !pending_reg)
    else $error("pending flag not cleared by write one");

  chk_irq_masked: assert property (
    !irqEnable_reg |=> !timerIrq)
    else $error("interrupt passed while masked");

  chk_irq_forward: assert property (
    (pending_reg && irqEnable_reg) |=> timerIrq)
    else $error("enabled pending interrupt not forwarded");

  chk_pend_set: assert property (
    zeroEvent |=> pending_reg ##1 (pending_reg || $past(pendClear)))
    else $error("reaching zero did not set pending flag");

  cov_reload_cycle: cover property (
    tickUse && ctlReload && liveCount_reg == `PDT_RST_COUNT);

  cov_oneshot_done: cover property (
    state_reg == PDT_ST_COUNT ##1 state_reg == PDT_ST_DONE);

  cov_irq_raised: cover property (!timerIrq ##1 timerIrq);

  cov_set_and_clear: cover property (zeroEvent && pendClear);

endmodule // pdt_timer

// ### test/test_pdt_timer.sv
`include "pdt_regs.svh"

module test_pdt_timer
  import pdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        ref_clk;
  logic        sys_rst;
  logic [3:0]  regAddr;
  logic [15:0] regWrData;
  logic        regWr;
  logic        regRd;
  logic [15:0] regRdData;
  logic        timerIrq;
  int          nMismatch;
  int          checks;
  int          cyc;

  pdt_timer u_pdt_timer (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .regAddr   (regAddr),
    .regWrData (regWrData),
    .regWr     (regWr),
    .regRd     (regRd),
    .regRdData (regRdData),
    .timerIrq  (timerIrq)
  );

  // free running clock and cycle count
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  // compare and tally
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  // read strobe, data taken in the following cycle only
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask

  task automatic rdChk(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    check(d, exp);
  endtask

  // wait for interrupt low, then its next rise, bounded
  task automatic waitRise(output int t);
    int n;
    n = 0;
    #1;
    while (timerIrq !== 1'b0 && n < 50) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (timerIrq !== 1'b1 && n < 40000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check({15'h0000, timerIrq}, 16'h0001);
    t = cyc;
  endtask

  // reset values, unmapped index, reserved control bits
  task automatic testResetRegs();
    check({15'h0000, timerIrq}, 16'h0000);
    rdChk(`PDT_OFS_CONTROL, 16'h0000);
    rdChk(`PDT_OFS_PERIOD, 16'h0000);
    rdChk(`PDT_OFS_COUNT, 16'h0000);
    rdChk(`PDT_OFS_STATUS, 16'h0000);
    rdChk(`PDT_OFS_ENABLE, 16'h0000);
    rdChk(4'hF, 16'h0000);
    wr(`PDT_OFS_CONTROL, 16'hFFFF);
    rdChk(`PDT_OFS_CONTROL, 16'h007F);
    wr(`PDT_OFS_CONTROL, 16'h0000);
  endtask

  // auto reload: event spacing is (period+1) ticks of 2^(code+1) clocks
  task automatic testRates();
    int t1;
    int t2;
    wr(`PDT_OFS_ENABLE, 16'h0100);
    for (int c = 0; c <= 10; c++) begin
      wr(`PDT_OFS_CONTROL, 16'h0030 | 16'(c));
      wr(`PDT_OFS_PERIOD, 16'h0003);
      wr(`PDT_OFS_CLEAR, 16'h0100);
      waitRise(t1);
      wr(`PDT_OFS_CLEAR, 16'h0100);
      waitRise(t2);
      check(16'(t2 - t1), 16'(32'h8 << c));
    end
    rdChk(`PDT_OFS_STATE, 16'h0001);
  endtask

  // one-shot stop, masking, status clear
  task automatic testOneShot();
    wr(`PDT_OFS_ENABLE, 16'h0000);
    wr(`PDT_OFS_CONTROL, 16'h0000);
    wr(`PDT_OFS_PERIOD, 16'h0002);
    wr(`PDT_OFS_STATUS, 16'h0100);
    wr(`PDT_OFS_CONTROL, 16'h0010);
    repeat (30) @(posedge ref_clk);
    rdChk(`PDT_OFS_COUNT, 16'h0000);
    rdChk(`PDT_OFS_STATUS, 16'h0100);
    rdChk(`PDT_OFS_STATE, 16'h0002);
    check({15'h0000, timerIrq}, 16'h0000);
    wr(`PDT_OFS_ENABLE, 16'h0100);
    @(posedge ref_clk);
    #1;
    check({15'h0000, timerIrq}, 16'h0001);
    wr(`PDT_OFS_STATUS, 16'h0100);
    repeat (2) @(posedge ref_clk);
    #1;
    check({15'h0000, timerIrq}, 16'h0000);
    repeat (40) @(posedge ref_clk);
    rdChk(`PDT_OFS_STATUS, 16'h0000);
    rdChk(`PDT_OFS_COUNT, 16'h0000);
  endtask

  // hold by count-enable, freeze by disable, resume
  task automatic testHold();
    logic [15:0] a;
    logic [15:0] b;
    wr(`PDT_OFS_CONTROL, 16'h0000);
    wr(`PDT_OFS_PERIOD, 16'h0100);
    wr(`PDT_OFS_CONTROL, 16'h0010);
    repeat (20) @(posedge ref_clk);
    wr(`PDT_OFS_CONTROL, 16'h0000);
    rd(`PDT_OFS_COUNT, a);
    check({15'h0000, a < 16'h0100}, 16'h0001);
    repeat (40) @(posedge ref_clk);
    rdChk(`PDT_OFS_COUNT, a);
    rdChk(`PDT_OFS_STATE, 16'h0003);
    wr(`PDT_OFS_CONTROL, 16'h0050);
    rd(`PDT_OFS_COUNT, a);
    repeat (40) @(posedge ref_clk);
    rdChk(`PDT_OFS_COUNT, a);
    rdChk(`PDT_OFS_PERIOD, 16'h0100);
    rdChk(`PDT_OFS_STATE, 16'h0000);
    wr(`PDT_OFS_CONTROL, 16'h0010);
    repeat (20) @(posedge ref_clk);
    rd(`PDT_OFS_COUNT, b);
    check({15'h0000, b < a}, 16'h0001);
  endtask

  // verdict and end of run
  task automatic conclude();
    $display("mismatches %0d checks %0d", nMismatch, checks);
    if (nMismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    ref_clk   = 1'b0;
    sys_rst   = 1'b1;
    regAddr   = 4'h0;
    regWrData = 16'h0000;
    regWr     = 1'b0;
    regRd     = 1'b0;
    nMismatch = 0;
    checks    = 0;
    cyc       = 0;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    testResetRegs();
    testRates();
    testOneShot();
    testHold();
    conclude();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    nMismatch++;
    conclude();
  end

endmodule // test_pdt_timer
